// >>> pmcg_top.sv
`timescale 1ns/1ns
`default_nettype none
module pmcg_top (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       slow_mode_in,
	input  wire logic [3:0] cpu_prescale_in,
	input  wire logic [3:0] unit_divide_in,
	input  wire logic [3:0] wait_divide_in,
	input  wire logic       wait_for_interrupt_mode_in,
	input  wire logic       halt_instr_in,
	input  wire logic       watchdog_enabled_in,
	input  wire logic       stop_request_in,
	input  wire logic       irq_ack_in,
	input  wire logic       wakeup_pin_in,
	output logic            cpu_clk_en_out,
	output logic            periph_clk_en_out,
	output logic            fetch_enable_out,
	output logic [2:0]      mode_out
);
	pmcg_pkg::pmcg_state_t state_r;
	pmcg_pkg::pmcg_state_t state_nxt;
	logic [1:0] wake_sync_r;
	logic       wake_seen_r;
	logic [1:0] wake_cnt_r;
	logic [3:0] ratio;
	logic       tick;
	logic       cpu_en_nxt;
	logic       per_en_nxt;

	// Slow ratio adds prescaler and unit divider; saturates at max
	always_comb begin
		ratio = 4'h0;
		if (state_r == pmcg_pkg::PMCG_WAIT) begin
			ratio = wait_divide_in;
		end else if (slow_mode_in) begin
			ratio = ({1'b0, cpu_prescale_in} + {1'b0, unit_divide_in} > 5'h0f) ?
				4'hf : 4'(cpu_prescale_in + unit_divide_in);
		end
	end

	pmcg_divider u_div (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.ratio_in (ratio),
		.tick_out (tick)
	);

	// Wake pin is asynchronous: two flops before use
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wake_sync_r <= pmcg_pkg::PMCG_SYNC_RESET;
			wake_seen_r <= 1'b0;
		end else begin
			wake_sync_r <= {wake_sync_r[0], wakeup_pin_in};
			wake_seen_r <= wake_sync_r[1];
		end
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			pmcg_pkg::PMCG_RUN: begin
				if (halt_instr_in && !watchdog_enabled_in) begin
					state_nxt = pmcg_pkg::PMCG_HALT;
				end else if (stop_request_in) begin
					state_nxt = pmcg_pkg::PMCG_STOP;
				end else if (wait_for_interrupt_mode_in) begin
					state_nxt = pmcg_pkg::PMCG_WAIT;
				end
			end
			pmcg_pkg::PMCG_WAIT: begin
				if (irq_ack_in) begin
					state_nxt = pmcg_pkg::PMCG_RUN;
				end
			end
			pmcg_pkg::PMCG_STOP: begin
				// Rising edge only, so a stuck-high pin cannot bounce back
				if (wake_sync_r[1] && !wake_seen_r) begin
					state_nxt = pmcg_pkg::PMCG_WAKE;
				end
			end
			pmcg_pkg::PMCG_WAKE: begin
				if (wake_cnt_r == pmcg_pkg::PMCG_WAKE_CYCLES) begin
					state_nxt = pmcg_pkg::PMCG_RUN;
				end
			end
			pmcg_pkg::PMCG_HALT: begin
				state_nxt = pmcg_pkg::PMCG_HALT;
			end
			default: begin
				state_nxt = pmcg_pkg::PMCG_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_r <= pmcg_pkg::PMCG_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Settling cycles before enables return, clean restart edge
	always_ff @(posedge clk_in) begin
		if (rst_in || state_r != pmcg_pkg::PMCG_WAKE) begin
			wake_cnt_r <= 2'h0;
		end else begin
			wake_cnt_r <= wake_cnt_r + 2'h1;
		end
	end

	// Enables registered, sampled by latch-based gates downstream
	always_comb begin
		cpu_en_nxt = 1'b0;
		per_en_nxt = 1'b0;
		case (state_nxt)
			pmcg_pkg::PMCG_RUN: begin
				cpu_en_nxt = slow_mode_in ? tick : 1'b1;
				per_en_nxt = slow_mode_in ? tick : 1'b1;
			end
			pmcg_pkg::PMCG_WAIT: begin
				per_en_nxt = tick;
			end
			default: begin
				cpu_en_nxt = 1'b0;
				per_en_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cpu_clk_en_out    <= 1'b0;
			periph_clk_en_out <= 1'b0;
			fetch_enable_out  <= 1'b0;
			mode_out          <= 3'h0;
		end else begin
			cpu_clk_en_out    <= cpu_en_nxt;
			periph_clk_en_out <= per_en_nxt;
			fetch_enable_out  <= (state_nxt == pmcg_pkg::PMCG_RUN);
			mode_out          <= state_nxt;
		end
	end

	sequence s_stop_entry;
		state_r == pmcg_pkg::PMCG_STOP;
	endsequence

	// Wait held with undivided peripheral clock and no acknowledge
	sequence s_wait_full;
		state_r == pmcg_pkg::PMCG_WAIT && wait_divide_in == 4'h0 && !irq_ack_in;
	endsequence

	property p_halt_sticks;
		@(posedge clk_in) disable iff (rst_in)
		state_r == pmcg_pkg::PMCG_HALT |=> state_r == pmcg_pkg::PMCG_HALT;
	endproperty
	a_halt_sticks: assert property (p_halt_sticks) else $error("Halt left");

	property p_halt_frozen;
		@(posedge clk_in) disable iff (rst_in)
		state_r == pmcg_pkg::PMCG_HALT |=> !cpu_clk_en_out && !periph_clk_en_out;
	endproperty
	a_halt_frozen: assert property (p_halt_frozen) else $error("Clock in halt");

	property p_halt_entry;
		@(posedge clk_in) disable iff (rst_in)
		state_r == pmcg_pkg::PMCG_RUN && halt_instr_in && !watchdog_enabled_in
			|=> state_r == pmcg_pkg::PMCG_HALT;
	endproperty
	a_halt_entry: assert property (p_halt_entry) else $error("No halt");

	property p_wait_core_off;
		@(posedge clk_in) disable iff (rst_in)
		state_r == pmcg_pkg::PMCG_WAIT && !irq_ack_in |=> !cpu_clk_en_out && !fetch_enable_out;
	endproperty
	a_wait_core_off: assert property (p_wait_core_off) else $error("Core ran in wait");

	property p_wait_exit;
		@(posedge clk_in) disable iff (rst_in)
		state_r == pmcg_pkg::PMCG_WAIT && irq_ack_in |=> fetch_enable_out;
	endproperty
	a_wait_exit: assert property (p_wait_exit) else $error("Wait not left");

	property p_wait_periph;
		@(posedge clk_in) disable iff (rst_in)
		s_wait_full ##1 s_wait_full |=> periph_clk_en_out;
	endproperty
	a_wait_periph: assert property (p_wait_periph) else $error("Periph off in wait");

	property p_run_full;
		@(posedge clk_in) disable iff (rst_in)
		state_nxt == pmcg_pkg::PMCG_RUN && !slow_mode_in |=> cpu_clk_en_out && periph_clk_en_out;
	endproperty
	a_run_full: assert property (p_run_full) else $error("Run not full");

	property p_slow_gaps;
		@(posedge clk_in) disable iff (rst_in)
		state_r == pmcg_pkg::PMCG_RUN && slow_mode_in && cpu_prescale_in != 4'h0
			&& $past(state_r) == pmcg_pkg::PMCG_RUN && $past(slow_mode_in)
			&& $past(cpu_prescale_in) != 4'h0
			&& cpu_clk_en_out |=> !cpu_clk_en_out;
	endproperty
	a_slow_gaps: assert property (p_slow_gaps) else $error("Slow not divided");

	property p_stop_frozen;
		@(posedge clk_in) disable iff (rst_in)
		s_stop_entry |=> !cpu_clk_en_out && !fetch_enable_out;
	endproperty
	a_stop_frozen: assert property (p_stop_frozen) else $error("Clock in stop");

	property p_wake_restart;
		@(posedge clk_in) disable iff (rst_in)
		s_stop_entry ##1 state_r == pmcg_pkg::PMCG_WAKE |-> ##[1:4] fetch_enable_out;
	endproperty
	a_wake_restart: assert property (p_wake_restart) else $error("No resume");
endmodule
`default_nettype wire

// >>> pmcg_pkg.sv
// Summary of operation
// - Run: core and peripherals at full clock
// - Slow: both clocks lowered by prescaler and divider
// - Wait: no fetch until interrupt acknowledged
// - Wait: core clock gated, peripherals run divided by wait divider
// - Halt without watchdog: all clocks stopped, frozen
// - Halt left only through reset
// - Stop: all frozen until external wake-up pin
package pmcg_pkg;
	typedef enum logic [2:0] {
		PMCG_RUN  = 3'h0,
		PMCG_WAIT = 3'h1,
		PMCG_STOP = 3'h3,
		PMCG_WAKE = 3'h2,
		PMCG_HALT = 3'h6
	} pmcg_state_t;
	localparam int          PMCG_DIV_W       = 4;
	localparam logic [3:0]  PMCG_DIV_RESET   = 4'h0;
	localparam logic [3:0]  PMCG_CNT_RESET   = 4'h0;
	localparam logic [1:0]  PMCG_WAKE_CYCLES = 2'h2;
	localparam logic [1:0]  PMCG_SYNC_RESET  = 2'h0;
endpackage

// >>> pmcg_divider.sv
`timescale 1ns/1ns
`default_nettype none
module pmcg_divider (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic [3:0] ratio_in,
	output logic            tick_out
);
	logic [3:0] cnt_r;

	// Ratio 0 gives a tick on every edge
	always_ff @(posedge clk_in) begin
		if (rst_in || cnt_r >= ratio_in) begin
			cnt_r <= pmcg_pkg::PMCG_CNT_RESET;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			tick_out <= 1'b0;
		end else begin
			tick_out <= (cnt_r >= ratio_in);
		end
	end
endmodule
`default_nettype wire

// >>> pmcg_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module pmcg_core_model (
	input  wire logic clk_in,
	input  wire logic ack_req_in,
	input  wire logic stop_req_in,
	input  wire logic wake_req_in,
	output logic      irq_ack_out,
	output logic      stop_request_out,
	output logic      wakeup_pin_out
);
	logic ack_q, stop_q, wake_q;
	initial {ack_q, stop_q, wake_q, irq_ack_out, stop_request_out, wakeup_pin_out} = 6'h00;
	// Requests one cycle late, like a real core answering
	always @(posedge clk_in) {ack_q, stop_q, wake_q} <= {ack_req_in, stop_req_in, wake_req_in};
	always @(negedge clk_in) begin
		irq_ack_out      <= ack_q;
		stop_request_out <= stop_q;
		wakeup_pin_out   <= wake_q;
	end
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n,e,g) begin n_checks++; if ((g)!==(e)) begin failures++; \
	$display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb;
	logic       clk_in, rst_in, slow, wait_p, halt_p, wd, ack_q, stop_q, wake_q;
	logic [3:0] pre, div, wdiv;
	logic       ack, stopr, pin, cpu_en, per_en, fetch, busy;
	logic [2:0] mode;
	int         failures, n_checks, cyc, k, n_cpu;
	pmcg_top i_pmcg_top (.clk_in(clk_in), .rst_in(rst_in), .slow_mode_in(slow),
		.cpu_prescale_in(pre), .unit_divide_in(div), .wait_divide_in(wdiv),
		.wait_for_interrupt_mode_in(wait_p), .halt_instr_in(halt_p),
		.watchdog_enabled_in(wd), .stop_request_in(stopr), .irq_ack_in(ack),
		.wakeup_pin_in(pin), .cpu_clk_en_out(cpu_en), .periph_clk_en_out(per_en),
		.fetch_enable_out(fetch), .mode_out(mode));
	pmcg_core_model i_pmcg_core_model (.clk_in(clk_in), .ack_req_in(ack_q),
		.stop_req_in(stop_q), .wake_req_in(wake_q), .irq_ack_out(ack),
		.stop_request_out(stopr), .wakeup_pin_out(pin));
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	task automatic step(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic chk_out(input logic [2:0] m, input logic c, input logic p, input logic f);
		`CHK("mode", m, mode)
		`CHK("cpu_en", c, cpu_en)
		`CHK("per_en", p, per_en)
		`CHK("fetch", f, fetch)
	endtask
	task automatic count_per(input int n, output int c);
		c = 0;
		n_cpu = 0;
		busy = 1'b0;
		repeat (n) begin
			step(1);
			c += (per_en === 1'b1);
			n_cpu += (cpu_en === 1'b1);
			busy = busy | (cpu_en !== 1'b0) | (fetch !== 1'b0);
		end
	endtask
	task automatic t_slow;
		slow = 1'b1;
		pre = 4'h1;
		div = 4'h2;
		step(2);
		count_per(16, k);
		`CHK("slow_rate", 4, k)
		`CHK("slow_cpu", 4, n_cpu)
		slow = 1'b0;
		step(2);
		chk_out(3'h0, 1'b1, 1'b1, 1'b1);
	endtask
	task automatic t_wait;
		wdiv = 4'h1;
		wait_p = 1'b1;
		step(1);
		wait_p = 1'b0;
		`CHK("wait_mode", 3'h1, mode)
		count_per(8, k);
		`CHK("wait_rate", 4, k)
		`CHK("wait_busy", 1'b0, busy)
		ack_q = 1'b1;
		step(1);
		ack_q = 1'b0;
		step(1);
		chk_out(3'h0, 1'b1, 1'b1, 1'b1);
		wdiv = 4'h0;
		wait_p = 1'b1;
		step(1);
		wait_p = 1'b0;
		count_per(6, k);
		`CHK("wait_full", 6, k)
		`CHK("wait_busy0", 1'b0, busy)
		ack_q = 1'b1;
		step(1);
		ack_q = 1'b0;
		step(1);
		chk_out(3'h0, 1'b1, 1'b1, 1'b1);
	endtask
	task automatic t_halt;
		wd = 1'b1;
		halt_p = 1'b1;
		step(1);
		halt_p = 1'b0;
		`CHK("halt_wd", 3'h0, mode)
		wd = 1'b0;
		halt_p = 1'b1;
		step(1);
		halt_p = 1'b0;
		chk_out(3'h6, 1'b0, 1'b0, 1'b0);
		ack_q = 1'b1;
		wake_q = 1'b1;
		step(1);
		ack_q = 1'b0;
		step(12);
		wake_q = 1'b0;
		step(3);
		chk_out(3'h6, 1'b0, 1'b0, 1'b0);
		rst_in = 1'b1;
		step(1);
		rst_in = 1'b0;
		step(1);
		chk_out(3'h0, 1'b1, 1'b1, 1'b1);
	endtask
	task automatic t_stop;
		stop_q = 1'b1;
		step(1);
		stop_q = 1'b0;
		step(1);
		chk_out(3'h3, 1'b0, 1'b0, 1'b0);
		ack_q = 1'b1;
		step(1);
		ack_q = 1'b0;
		step(6);
		chk_out(3'h3, 1'b0, 1'b0, 1'b0);
		wake_q = 1'b1;
		k = 0;
		while (mode !== 3'h0 && k < 15) begin
			step(1);
			k++;
		end
		chk_out(3'h0, 1'b1, 1'b1, 1'b1);
		`CHK("wake_lat", 1'b1, (k > 3 && k < 12))
		wake_q = 1'b0;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Whole run needs about a hundred cycles
	always @(posedge clk_in) begin
		cyc++;
		if (cyc > 5000) begin
			failures++;
			tally_and_finish;
		end
	end
	initial begin
		{rst_in, slow, wait_p, halt_p, wd, ack_q, stop_q, wake_q} = 8'h80;
		{pre, div, wdiv} = 12'h000;
		step(20);
		rst_in = 1'b0;
		step(1);
		chk_out(3'h0, 1'b1, 1'b1, 1'b1);
		t_slow;
		t_wait;
		t_halt;
		t_stop;
		tally_and_finish;
	end
endmodule
`default_nettype wire
